// [hdl/dpsg_axil.v]
// Purpose: AXI4-Lite slave front end for the channel registers
// Assumes: one write and one read outstanding at most
// Notes:   wr_en pulses one cycle with stable address; answer on next edge
`timescale 1ns/1ps
`default_nettype none
`include "dpsg_defs.vh"
module dpsg_axil (
   input  wire        aclk,
   input  wire        aresetn,
   input  wire [7:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [7:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   output reg         wr_en_ff,
   output reg  [7:0]  wr_addr_ff,
   output reg  [31:0] wr_data_ff,
   output reg  [3:0]  wr_strb_ff,
   input  wire        wr_err,
   output reg  [7:0]  rd_addr_ff,
   input  wire [31:0] rd_data,
   input  wire        rd_err
);
   reg aw_got_ff;
   reg w_got_ff;
   reg rpend_ff;
   // ==========================================
   // write channels, taken in either order
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `DPSG_RESP_OKAY;
         aw_got_ff     <= 1'b0;
         w_got_ff      <= 1'b0;
         wr_en_ff      <= 1'b0;
         wr_addr_ff    <= 8'h00;
         wr_data_ff    <= `DPSG_ZERO32;
         wr_strb_ff    <= 4'h0;
      end else begin
         wr_en_ff <= 1'b0;
         if (s_axi_awvalid && s_axi_awready) begin
            wr_addr_ff    <= s_axi_awaddr;
            aw_got_ff     <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wr_data_ff   <= s_axi_wdata;
            wr_strb_ff   <= s_axi_wstrb;
            w_got_ff     <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (aw_got_ff && w_got_ff && !wr_en_ff && !s_axi_bvalid) begin
            wr_en_ff <= 1'b1;
         end
         if (wr_en_ff) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_err ? `DPSG_RESP_DECERR : `DPSG_RESP_OKAY;
            aw_got_ff    <= 1'b0;
            w_got_ff     <= 1'b0;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end
   // ==========================================
   // read channel: address taken, data one cycle later
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= `DPSG_ZERO32;
         s_axi_rresp   <= `DPSG_RESP_OKAY;
         rd_addr_ff    <= 8'h00;
         rpend_ff      <= 1'b0;
      end else begin
         if (s_axi_arvalid && s_axi_arready) begin
            rd_addr_ff    <= s_axi_araddr;
            s_axi_arready <= 1'b0;
            rpend_ff      <= 1'b1;
         end
         if (rpend_ff) begin
            rpend_ff     <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_data;
            s_axi_rresp  <= rd_err ? `DPSG_RESP_DECERR : `DPSG_RESP_OKAY;
         end
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// [hdl/dpsg_defs.vh]
// Purpose: constants shared by the peripheral scatter/gather channel
// Assumes: 8-bit register byte addresses, 32-bit words
// Notes:   descriptor control word layout and cycle-control codes
`ifndef DPSG_DEFS_VH
`define DPSG_DEFS_VH
// ==========================================
// register byte offsets
`define DPSG_OFF_CFG        8'h00
`define DPSG_OFF_CHEN_SET   8'h04
`define DPSG_OFF_CHEN_CLR   8'h08
`define DPSG_OFF_PRI_SRC    8'h10
`define DPSG_OFF_PRI_DST    8'h14
`define DPSG_OFF_PRI_CTRL   8'h18
`define DPSG_OFF_ALT_SRC    8'h20
`define DPSG_OFF_ALT_DST    8'h24
`define DPSG_OFF_ALT_CTRL   8'h28
`define DPSG_OFF_ALT_SPARE  8'h2c
`define DPSG_OFF_STATUS     8'h30
`define DPSG_OFF_IRQ_STAT   8'h34
`define DPSG_OFF_IRQ_MASK   8'h38
// ==========================================
// descriptor control word fields
`define DPSG_CC_HI          2
`define DPSG_CC_LO          0
`define DPSG_N_HI           13
`define DPSG_N_LO           4
`define DPSG_R_HI           17
`define DPSG_R_LO           14
`define DPSG_SINC_HI        27
`define DPSG_SINC_LO        26
`define DPSG_DINC_HI        31
`define DPSG_DINC_LO        30
// ==========================================
// cycle-control and address-increment codes
`define DPSG_CC_INVALID     3'h0
`define DPSG_CC_BASIC       3'h1
`define DPSG_CC_PSG_PRI     3'h6
`define DPSG_CC_PSG_ALT     3'h7
`define DPSG_INC_NONE       2'h3
`define DPSG_INC_WORD       2'h2
// ==========================================
// interrupt bits, response codes, reset values, last descriptor word index
`define DPSG_IRQ_DONE       0
`define DPSG_IRQ_ERR        1
`define DPSG_RESP_OKAY      2'h0
`define DPSG_RESP_DECERR    2'h3
`define DPSG_ZERO32         32'h0000_0000
`define DPSG_DESC_WORDS     2'h3
`endif

// [hdl/dpsg_mem.v]
// Purpose: single-access memory port for descriptor copy and task moves
// Assumes: mem_req is held until mem_ack, read data valid with mem_ack
// Notes:   one access at a time; start is ignored while busy
`timescale 1ns/1ps
`default_nettype none
`include "dpsg_defs.vh"
module dpsg_mem (
   input  wire        aclk,
   input  wire        aresetn,
   input  wire        start,
   input  wire        we,
   input  wire [31:0] addr,
   input  wire [31:0] wdata,
   output reg         done_ff,
   output reg  [31:0] rdata_ff,
   output reg         mem_req_ff,
   output reg         mem_we_ff,
   output reg  [31:0] mem_addr_ff,
   output reg  [31:0] mem_wdata_ff,
   input  wire        mem_ack,
   input  wire [31:0] mem_rdata
);
   // ==========================================
   // request / acknowledge
   always @(posedge aclk) begin
      if (!aresetn) begin
         done_ff      <= 1'b0;
         rdata_ff     <= `DPSG_ZERO32;
         mem_req_ff   <= 1'b0;
         mem_we_ff    <= 1'b0;
         mem_addr_ff  <= `DPSG_ZERO32;
         mem_wdata_ff <= `DPSG_ZERO32;
      end else begin
         done_ff <= 1'b0;
         if (mem_req_ff && mem_ack) begin
            mem_req_ff <= 1'b0;
            done_ff    <= 1'b1;
            rdata_ff   <= mem_rdata;
         end else if (!mem_req_ff && start) begin
            mem_req_ff   <= 1'b1;
            mem_we_ff    <= we;
            mem_addr_ff  <= addr;
            mem_wdata_ff <= wdata;
         end
      end
   end
endmodule
`default_nettype wire

// [hdl/dpsg_top.v]
// Purpose: one DMA channel running peripheral scatter/gather sequencing
// Assumes: external arbiter grants this channel via arb_grant
// Notes:   data moves are whole 32-bit words; size fields are not decoded
//
// What this block does
// - a won request in scatter/gather mode copies four words, then runs that task
// - after a descriptor copy the copied task starts without a new request
// - after a task the next copy waits for a new request that wins arbitration
// - copy and task alternate until cycle control reads invalid, basic or an unknown code
// - the end of the whole operation raises the processor interrupt
// - after its last transfer the primary control is set to invalid 000
// - a task pauses for a new won request after every 2^R transfers
// - a final task with basic code ends with a transfer-end interrupt
`timescale 1ns/1ps
`default_nettype none
`include "dpsg_defs.vh"
module dpsg_top (
   input  wire        aclk,
   input  wire        aresetn,
   input  wire [7:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   output wire [1:0]  s_axi_bresp,
   output wire        s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [7:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output wire [31:0] s_axi_rdata,
   output wire [1:0]  s_axi_rresp,
   output wire        s_axi_rvalid,
   input  wire        s_axi_rready,
   input  wire        dma_req,
   input  wire        arb_grant,
   output reg         dma_ack_ff,
   output wire        mem_req,
   output wire        mem_we,
   output wire [31:0] mem_addr,
   output wire [31:0] mem_wdata,
   input  wire        mem_ack,
   input  wire [31:0] mem_rdata,
   output reg         irq_ff
);
   // ==========================================
   // states
   localparam [5:0] S_IDLE = 6'h01;
   localparam [5:0] S_CP   = 6'h02;
   localparam [5:0] S_CHK  = 6'h04;
   localparam [5:0] S_RD   = 6'h08;
   localparam [5:0] S_WR   = 6'h10;
   localparam [5:0] S_ARB  = 6'h20;

   reg  [5:0]  state_ff;
   reg         iss_ff;
   reg         master_en_ff;
   reg         ch_en_ff;
   reg  [31:0] pri_src_ff;
   reg  [31:0] pri_dst_ff;
   reg  [31:0] pri_ctrl_ff;
   reg  [31:0] alt_ff [0:3];
   reg  [1:0]  cp_idx_ff;
   reg  [9:0]  rem_ff;
   reg  [10:0] burst_ff;
   reg  [31:0] tdata_ff;
   reg  [1:0]  irq_stat_ff;
   reg  [1:0]  irq_mask_ff;
   reg  [1:0]  irq_set;
   reg         finish;
   reg  [31:0] rd_data;
   reg         rd_err;
   reg         wr_err;
   reg         mem_start;
   reg         mem_we_c;
   reg  [31:0] mem_addr_c;
   wire        wr_en;
   wire [7:0]  wr_addr;
   wire [31:0] wr_data;
   wire [3:0]  wr_strb;
   wire [7:0]  rd_addr;
   wire        mem_done;
   wire [31:0] mem_rd;
   wire        req_win;
   wire [2:0]  pri_cc;
   wire [2:0]  alt_cc;
   wire [9:0]  pri_n;
   wire [10:0] burst_nxt;
   integer     i;

   // ==========================================
   // functions
   // pointers mark the last item, so the current address counts back from the end
   function [31:0] item_addr;
      input [31:0] end_ptr;
      input [9:0]  rem;
      input [1:0]  inc;
      begin
         if (inc == `DPSG_INC_NONE)
            item_addr = end_ptr;
         else
            item_addr = end_ptr - ({22'h0, rem} << inc);
      end
   endfunction

   function [31:0] apply_strb;
      input [31:0] old;
      input [31:0] nw;
      input [3:0]  strb;
      integer b;
      begin
         apply_strb = old;
         for (b = 0; b < 4; b = b + 1)
            if (strb[b])
               apply_strb[b*8 +: 8] = nw[b*8 +: 8];
      end
   endfunction

   assign pri_cc    = pri_ctrl_ff[`DPSG_CC_HI:`DPSG_CC_LO];
   assign pri_n     = pri_ctrl_ff[`DPSG_N_HI:`DPSG_N_LO];
   assign alt_cc    = alt_ff[2][`DPSG_CC_HI:`DPSG_CC_LO];
   assign burst_nxt = burst_ff + 11'h001;
   // a request only counts once it has won arbitration and the channel is enabled
   assign req_win   = dma_req && arb_grant && master_en_ff && ch_en_ff;

   // ==========================================
   // bus slave and memory port
   dpsg_axil u_axil (
      .aclk          (aclk),
      .aresetn       (aresetn),
      .s_axi_awaddr  (s_axi_awaddr),
      .s_axi_awvalid (s_axi_awvalid),
      .s_axi_awready (s_axi_awready),
      .s_axi_wdata   (s_axi_wdata),
      .s_axi_wstrb   (s_axi_wstrb),
      .s_axi_wvalid  (s_axi_wvalid),
      .s_axi_wready  (s_axi_wready),
      .s_axi_bresp   (s_axi_bresp),
      .s_axi_bvalid  (s_axi_bvalid),
      .s_axi_bready  (s_axi_bready),
      .s_axi_araddr  (s_axi_araddr),
      .s_axi_arvalid (s_axi_arvalid),
      .s_axi_arready (s_axi_arready),
      .s_axi_rdata   (s_axi_rdata),
      .s_axi_rresp   (s_axi_rresp),
      .s_axi_rvalid  (s_axi_rvalid),
      .s_axi_rready  (s_axi_rready),
      .wr_en_ff      (wr_en),
      .wr_addr_ff    (wr_addr),
      .wr_data_ff    (wr_data),
      .wr_strb_ff    (wr_strb),
      .wr_err        (wr_err),
      .rd_addr_ff    (rd_addr),
      .rd_data       (rd_data),
      .rd_err        (rd_err)
   );

   dpsg_mem u_mem (
      .aclk         (aclk),
      .aresetn      (aresetn),
      .start        (mem_start),
      .we           (mem_we_c),
      .addr         (mem_addr_c),
      .wdata        (tdata_ff),
      .done_ff      (mem_done),
      .rdata_ff     (mem_rd),
      .mem_req_ff   (mem_req),
      .mem_we_ff    (mem_we),
      .mem_addr_ff  (mem_addr),
      .mem_wdata_ff (mem_wdata),
      .mem_ack      (mem_ack),
      .mem_rdata    (mem_rdata)
   );

   // ==========================================
   // memory command selection
   always @* begin
      mem_start  = 1'b0;
      mem_we_c   = 1'b0;
      mem_addr_c = `DPSG_ZERO32;
      case (state_ff)
         S_CP: begin
            mem_start  = !iss_ff;
            mem_addr_c = item_addr(pri_src_ff, pri_n, `DPSG_INC_WORD);
         end
         S_RD: begin
            mem_start  = !iss_ff;
            mem_addr_c = item_addr(alt_ff[0], rem_ff, alt_ff[2][`DPSG_SINC_HI:`DPSG_SINC_LO]);
         end
         S_WR: begin
            mem_start  = !iss_ff;
            mem_we_c   = 1'b1;
            mem_addr_c = item_addr(alt_ff[1], rem_ff, alt_ff[2][`DPSG_DINC_HI:`DPSG_DINC_LO]);
         end
         default: mem_start = 1'b0;
      endcase
   end

   // ==========================================
   // register read decode
   always @* begin
      rd_err  = 1'b0;
      rd_data = `DPSG_ZERO32;
      case (rd_addr)
         `DPSG_OFF_CFG:       rd_data = {31'h0, master_en_ff};
         `DPSG_OFF_CHEN_SET:  rd_data = {31'h0, ch_en_ff};
         `DPSG_OFF_CHEN_CLR:  rd_data = {31'h0, ch_en_ff};
         `DPSG_OFF_PRI_SRC:   rd_data = pri_src_ff;
         `DPSG_OFF_PRI_DST:   rd_data = pri_dst_ff;
         `DPSG_OFF_PRI_CTRL:  rd_data = pri_ctrl_ff;
         `DPSG_OFF_ALT_SRC:   rd_data = alt_ff[0];
         `DPSG_OFF_ALT_DST:   rd_data = alt_ff[1];
         `DPSG_OFF_ALT_CTRL:  rd_data = alt_ff[2];
         `DPSG_OFF_ALT_SPARE: rd_data = alt_ff[3];
         `DPSG_OFF_STATUS:    rd_data = {16'h0, rem_ff[7:0], 2'h0, state_ff};
         `DPSG_OFF_IRQ_STAT:  rd_data = {30'h0, irq_stat_ff};
         `DPSG_OFF_IRQ_MASK:  rd_data = {30'h0, irq_mask_ff};
         default:             rd_err  = 1'b1;
      endcase
   end

   // alt slot is written only by the copy engine, so it refuses writes
   always @* begin
      case (wr_addr)
         `DPSG_OFF_CFG, `DPSG_OFF_CHEN_SET, `DPSG_OFF_CHEN_CLR,
         `DPSG_OFF_PRI_SRC, `DPSG_OFF_PRI_DST, `DPSG_OFF_PRI_CTRL,
         `DPSG_OFF_IRQ_STAT, `DPSG_OFF_IRQ_MASK: wr_err = 1'b0;
         default:                                wr_err = 1'b1;
      endcase
   end

   // ==========================================
   // sequencer
   always @(posedge aclk) begin
      if (!aresetn) begin
         state_ff   <= S_IDLE;
         iss_ff     <= 1'b0;
         cp_idx_ff  <= 2'h0;
         rem_ff     <= 10'h000;
         burst_ff   <= 11'h000;
         tdata_ff   <= `DPSG_ZERO32;
         dma_ack_ff <= 1'b0;
         pri_ctrl_ff <= `DPSG_ZERO32;
         irq_set    <= 2'h0;
         finish     <= 1'b0;
         for (i = 0; i < 4; i = i + 1)
            alt_ff[i] <= `DPSG_ZERO32;
      end else begin
         dma_ack_ff <= 1'b0;
         irq_set    <= 2'h0;
         finish     <= 1'b0;
         if (mem_start)
            iss_ff <= 1'b1;
         if (mem_done)
            iss_ff <= 1'b0;
         case (state_ff)
            S_IDLE: begin
               if (req_win) begin
                  dma_ack_ff <= 1'b1;
                  if (pri_cc == `DPSG_CC_PSG_PRI) begin
                     cp_idx_ff <= 2'h0;
                     state_ff  <= S_CP;
                  end else begin
                     // primary not in scatter/gather primary mode: the chain is over
                     irq_set[`DPSG_IRQ_DONE] <= 1'b1;
                     finish <= 1'b1;
                  end
               end
            end
            S_CP: begin
               if (mem_done) begin
                  alt_ff[`DPSG_DESC_WORDS - pri_n[1:0]] <= mem_rd;
                  if (pri_n == 10'h000)
                     pri_ctrl_ff[`DPSG_CC_HI:`DPSG_CC_LO] <= `DPSG_CC_INVALID;
                  else
                     pri_ctrl_ff[`DPSG_N_HI:`DPSG_N_LO] <= pri_n - 10'h001;
                  cp_idx_ff <= cp_idx_ff + 2'h1;
                  // exactly four words, then straight into the task
                  if (cp_idx_ff == `DPSG_DESC_WORDS)
                     state_ff <= S_CHK;
               end
            end
            S_CHK: begin
               rem_ff   <= alt_ff[2][`DPSG_N_HI:`DPSG_N_LO];
               burst_ff <= 11'h000;
               if (alt_cc == `DPSG_CC_PSG_ALT || alt_cc == `DPSG_CC_BASIC) begin
                  state_ff <= S_RD;
               end else begin
                  // invalid or unknown task code ends the chain; unknown flags error
                  if (alt_cc != `DPSG_CC_INVALID)
                     irq_set[`DPSG_IRQ_ERR] <= 1'b1;
                  irq_set[`DPSG_IRQ_DONE] <= 1'b1;
                  finish   <= 1'b1;
                  state_ff <= S_IDLE;
               end
            end
            S_RD: begin
               if (mem_done) begin
                  tdata_ff <= mem_rd;
                  state_ff <= S_WR;
               end
            end
            S_WR: begin
               if (mem_done) begin
                  if (rem_ff == 10'h000) begin
                     state_ff <= S_IDLE;
                     if (alt_cc == `DPSG_CC_BASIC) begin
                        irq_set[`DPSG_IRQ_DONE] <= 1'b1;
                        finish <= 1'b1;
                     end
                  end else begin
                     rem_ff <= rem_ff - 10'h001;
                     if ({5'h00, burst_nxt} ==
                         (16'h0001 << alt_ff[2][`DPSG_R_HI:`DPSG_R_LO])) begin
                        burst_ff <= 11'h000;
                        state_ff <= S_ARB;
                     end else begin
                        burst_ff <= burst_nxt;
                        state_ff <= S_RD;
                     end
                  end
               end
            end
            S_ARB: begin
               if (req_win) begin
                  dma_ack_ff <= 1'b1;
                  state_ff   <= S_RD;
               end
            end
            default: state_ff <= S_IDLE;
         endcase
         // software write to primary control overrides the engine's update
         if (wr_en && wr_addr == `DPSG_OFF_PRI_CTRL)
            pri_ctrl_ff <= apply_strb(pri_ctrl_ff, wr_data, wr_strb);
      end
   end

   // ==========================================
   // software registers and interrupt
   always @(posedge aclk) begin
      if (!aresetn) begin
         master_en_ff <= 1'b0;
         ch_en_ff     <= 1'b0;
         pri_src_ff   <= `DPSG_ZERO32;
         pri_dst_ff   <= `DPSG_ZERO32;
         irq_stat_ff  <= 2'h0;
         irq_mask_ff  <= 2'h0;
         irq_ff       <= 1'b0;
      end else begin
         if (finish)
            ch_en_ff <= 1'b0;
         if (wr_en) begin
            case (wr_addr)
               `DPSG_OFF_CFG:      if (wr_strb[0]) master_en_ff <= wr_data[0];
               `DPSG_OFF_CHEN_SET: if (wr_strb[0] && wr_data[0]) ch_en_ff <= 1'b1;
               `DPSG_OFF_CHEN_CLR: if (wr_strb[0] && wr_data[0]) ch_en_ff <= 1'b0;
               `DPSG_OFF_PRI_SRC:  pri_src_ff <= apply_strb(pri_src_ff, wr_data, wr_strb);
               `DPSG_OFF_PRI_DST:  pri_dst_ff <= apply_strb(pri_dst_ff, wr_data, wr_strb);
               `DPSG_OFF_IRQ_MASK: if (wr_strb[0]) irq_mask_ff <= wr_data[1:0];
               default:            irq_mask_ff <= irq_mask_ff;
            endcase
         end
         // a new event in the clearing cycle survives the write-one clear
         if (wr_en && wr_addr == `DPSG_OFF_IRQ_STAT && wr_strb[0])
            irq_stat_ff <= (irq_stat_ff & ~wr_data[1:0]) | irq_set;
         else
            irq_stat_ff <= irq_stat_ff | irq_set;
         irq_ff <= |(irq_stat_ff & irq_mask_ff);
      end
   end
endmodule
`default_nettype wire

// [tb/dpsg_checker.sv]
// Purpose: port checks for dpsg_top
// Assumes: one clock, sync reset
// Notes:   bound at the foot
`timescale 1ns/1ps
`default_nettype none
module dpsg_checker (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        dma_req,
   input wire logic        arb_grant,
   input wire logic        dma_ack_ff,
   input wire logic        mem_req,
   input wire logic        mem_we,
   input wire logic        mem_ack,
   input wire logic [31:0] mem_addr,
   input wire logic        irq_ff
);
   // ====
   // assertions
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_ack_one_pulse: assert property (dma_ack_ff |=> !dma_ack_ff)
      else $error("ack longer than a cycle");
   a_ack_has_cause: assert property (dma_ack_ff |-> $past(dma_req && arb_grant))
      else $error("ack without won request");
   a_no_grant_ack: assert property (!arb_grant |=> !dma_ack_ff)
      else $error("ack without grant");
   a_ack_starts_mem: assert property ($rose(dma_ack_ff) |-> ##[0:8] mem_req)
      else $error("no access after ack");
   a_mem_req_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
      else $error("access dropped early");
   a_mem_we_hold: assert property (mem_req && !mem_ack |=> $stable(mem_we))
      else $error("access kind changed");
   a_mem_ack_drop: assert property (mem_req && mem_ack |=> !mem_req)
      else $error("access held after ack");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
      else $error("read answer withdrawn");
   a_irq_at_rest: assert property ($rose(irq_ff) |-> !mem_req)
      else $error("irq while moving data");
   c_ack: cover property (dma_ack_ff);
   c_write: cover property (mem_req && mem_we && mem_ack);
   c_irq: cover property ($rose(irq_ff));
endmodule
bind dpsg_top dpsg_checker u_chk (.aclk(aclk), .aresetn(aresetn), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .dma_req(dma_req), .arb_grant(arb_grant),
   .dma_ack_ff(dma_ack_ff), .mem_req(mem_req), .mem_we(mem_we), .mem_ack(mem_ack),
   .mem_addr(mem_addr), .irq_ff(irq_ff));
`default_nettype wire

// [tb/dpsg_mem_model.sv]
// Purpose: requesting peripheral plus memory
// Assumes: word index from address bits 7:2
// Notes:   answer delay varies; data line changes when idle
`timescale 1ns/1ps
`default_nettype none
module dpsg_mem_model (
   input  wire logic        aclk,
   input  wire logic        go,
   input  wire logic        dma_ack_ff,
   input  wire logic        mem_req,
   input  wire logic        mem_we,
   input  wire logic [31:0] mem_addr,
   input  wire logic [31:0] mem_wdata,
   output var  logic        dma_req,
   output var  logic        mem_ack,
   output var  logic [31:0] mem_rdata
);
   logic [31:0] mem [0:63];
   logic [1:0]  wt;
   initial begin
      dma_req = 1'b0;
      mem_ack = 1'b0;
      mem_rdata = 32'h0;
      wt = 2'h0;
      for (int i = 0; i < 64; i++) mem[i] = 32'ha5a50000 + i;
   end
   // ====
   // request stays up until taken
   always @(posedge aclk) begin
      if (go) dma_req <= 1'b1;
      else if (dma_ack_ff) dma_req <= 1'b0;
   end
   // odd words answer at once, others after four cycles
   always @(posedge aclk) begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ack) begin
         wt <= wt + 2'h1;
         if (wt == 2'h3 || mem_addr[2]) begin
            mem_ack <= 1'b1;
            wt <= 2'h0;
            if (mem_we) mem[mem_addr[7:2]] <= mem_wdata;
            else mem_rdata <= mem[mem_addr[7:2]];
         end
      end
   end
endmodule
`default_nettype wire

// [tb/tb.sv]
// Purpose: two-task chain through dpsg_top
// Assumes: list at words 8..15
// Notes:   bready held high
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, arvalid = 0, rready = 0;
   logic        arb_grant = 0, go = 0;
   logic [7:0]  awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rv;
   wire         awready, wready, bvalid, arready, rvalid, dma_req, dma_ack_ff;
   wire         mem_req, mem_we, mem_ack, irq_ff;
   wire  [1:0]  bresp, rresp;
   wire  [31:0] rdata, mem_addr, mem_wdata, mem_rdata;
   int          fail_count = 0, check_count = 0;
   always #2.5 aclk = ~aclk;
   dpsg_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .dma_req(dma_req),
      .arb_grant(arb_grant), .dma_ack_ff(dma_ack_ff), .mem_req(mem_req), .mem_we(mem_we),
      .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
      .irq_ff(irq_ff));
   dpsg_mem_model mdl (.aclk(aclk), .go(go), .dma_ack_ff(dma_ack_ff), .mem_req(mem_req),
      .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .dma_req(dma_req),
      .mem_ack(mem_ack), .mem_rdata(mem_rdata));
   // ====
   // shared tasks
   task chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task print_verdict;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task hang(inout int n);
      n++;
      if (n > 300) begin
         fail_count++;
         $display("unexpected at %0t: wait ran out", $time);
         print_verdict;
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      n = 0;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         hang(n);
      end while (!bvalid);
      chk({30'h0, bresp}, {30'h0, er});
   endtask
   // rready rises with the request and stays up
   task rd(input logic [7:0] a, input logic [1:0] er);
      int n;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      n = 0;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
         hang(n);
      end while (!(rvalid && rready));
      rv = rdata;
      chk({30'h0, rresp}, {30'h0, er});
   endtask
   task poll(input logic [5:0] s);
      for (int k = 0; k < 60; k++) begin
         rd(8'h30, 2'h0);
         if (rv[5:0] === s) break;
      end
      chk({26'h0, rv[5:0]}, {26'h0, s});
      if (rv[5:0] !== s) print_verdict;
   endtask
   // grant stays low for d cycles, no take meanwhile
   task take(input int d);
      int n;
      arb_grant <= (d == 0);
      go <= 1'b1;
      @(posedge aclk);
      go <= 1'b0;
      repeat (d) begin
         @(posedge aclk);
         chk({31'h0, dma_ack_ff}, 32'h0);
      end
      arb_grant <= 1'b1;
      n = 0;
      do begin
         @(posedge aclk);
         hang(n);
      end while (!dma_ack_ff);
   endtask
   // ====
   // main sequence
   initial begin
      #1;
      mdl.mem[8] = 32'h44;
      mdl.mem[9] = 32'h84;
      mdl.mem[10] = 32'haa008017;
      mdl.mem[12] = 32'h64;
      mdl.mem[13] = 32'hb4;
      mdl.mem[14] = 32'haa004051;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      rd(8'h38, 2'h0);
      chk(rv, 32'h0);
      rd(8'h3c, 2'h3);
      chk(rv, 32'h0);
      wr(8'h20, 32'h1, 2'h3);
      wr(8'h38, 32'h1, 2'h0);
      wr(8'h10, 32'h3c, 2'h0);
      wr(8'h18, 32'haa008076, 2'h0);
      wr(8'h00, 32'h1, 2'h0);
      wr(8'h04, 32'h1, 2'h0);
      take(0);
      poll(6'h01);
      for (int i = 0; i < 2; i++) chk(mdl.mem[32 + i], 32'ha5a50010 + i);
      rd(8'h24, 2'h0);
      chk(rv, 32'h84);
      take(40);
      poll(6'h20);
      chk(mdl.mem[42], 32'ha5a5002a);
      rd(8'h20, 2'h0);
      chk(rv, 32'h64);
      rd(8'h18, 2'h0);
      chk({29'h0, rv[2:0]}, 32'h0);
      take(0);
      poll(6'h20);
      take(0);
      poll(6'h01);
      repeat (2) @(posedge aclk);
      chk({31'h0, irq_ff}, 32'h1);
      for (int i = 0; i < 6; i++) chk(mdl.mem[40 + i], 32'ha5a50014 + i);
      rd(8'h04, 2'h0);
      chk(rv, 32'h0);
      wr(8'h34, 32'h1, 2'h0);
      repeat (3) @(posedge aclk);
      chk({31'h0, irq_ff}, 32'h0);
      print_verdict;
   end
endmodule
`default_nettype wire
